// *** rtl/pso_pkg.sv ***
// package: offsets, field layouts, reset values and codes of the pll override block
package pso_pkg;

   // ==========================================================
   // register map (byte addresses)
   localparam logic [7:0]  PSO_STATE_OVR_OFS    = 8'h00;
   localparam logic [7:0]  PSO_FORCED_INPUT_OFS = 8'h04;
   localparam logic [7:0]  PSO_STATUS_OFS       = 8'h08;

   // ==========================================================
   // field layouts
   localparam int          PSO_STATE_MSB        = 2;
   localparam int          PSO_INPUT_MSB        = 3;
   localparam int          PSO_NUM_INPUTS       = 4;

   // ==========================================================
   // reset values
   localparam logic [2:0]  PSO_STATE_OVR_RST    = 3'h0;
   localparam logic [3:0]  PSO_FORCED_INPUT_RST = 4'hF;

   // ==========================================================
   // state codes of the main digital pll control machine
   localparam logic [2:0]  PSO_ST_AUTO          = 3'h0;
   localparam logic [2:0]  PSO_ST_FREE_RUN      = 3'h1;
   localparam logic [2:0]  PSO_ST_HOLDOVER      = 3'h2;
   localparam logic [2:0]  PSO_ST_UNUSED        = 3'h3;
   localparam logic [2:0]  PSO_ST_LOCKED        = 3'h4;
   localparam logic [2:0]  PSO_ST_PRELOCK2      = 3'h5;
   localparam logic [2:0]  PSO_ST_PRELOCK       = 3'h6;
   localparam logic [2:0]  PSO_ST_PHASE_LOST    = 3'h7;

   // ==========================================================
   // forced input codes; zero leaves selection automatic
   localparam logic [3:0]  PSO_IN_AUTO          = 4'h0;
   localparam logic [3:0]  PSO_IN_SE1           = 4'h3;
   localparam logic [3:0]  PSO_IN_SE2           = 4'h4;
   localparam logic [3:0]  PSO_IN_DIFF1         = 4'h5;
   localparam logic [3:0]  PSO_IN_DIFF2         = 4'h6;

   // ==========================================================
   // bus answers
   localparam logic [1:0]  PSO_RESP_OKAY        = 2'h0;
   localparam logic [1:0]  PSO_RESP_SLVERR      = 2'h2;

endpackage

// *** rtl/pso_override.sv ***
// module: software override of the pll control state and of the equipment clock input
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - three-bit state override field, reset to automatic; code 011 unused.
// - zero lets the machine run; other valid codes force a jump to that state.
// - while a state is forced, input monitors cannot influence the machine.
// - four-bit forced input field; zero leaves selection to automatic mechanism.
// - forced field selects one of four inputs; other nonzero codes unused.
// - a forced input skips monitoring qualification and is treated valid.
// - with a forced input and not locked, acquisition proceeds toward locked.
// - a failing forced input causes no holdover and no disqualification.
// - forcing also raises the chosen input's priority to one, the highest.
module pso_override
   import pso_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // axi4-lite write address
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   // axi4-lite write response
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read address
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   // axi4-lite read data
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // from the pll control machine and input monitors
   input  wire logic [2:0]  sm_state,
   input  wire logic [3:0]  mon_valid,
   input  wire logic [3:0]  mon_fail,
   // to the pll control machine
   output var  logic        sm_force_r,
   output var  logic [2:0]  sm_force_state_r,
   output var  logic        sm_mon_enable_r,
   output var  logic        sm_acquire_r,
   output var  logic        sm_holdover_inhibit_r,
   // to the reference selector
   output var  logic [3:0]  input_valid_r,
   output var  logic [3:0]  input_prio1_r,
   output var  logic [3:0]  input_disq_inhibit_r,
   output var  logic [3:0]  input_fail_r
);

   // ==========================================================
   // decode helpers
   function automatic logic state_code_forces(input logic [2:0] code);
      state_code_forces = (code != PSO_ST_AUTO) && (code != PSO_ST_UNUSED);
   endfunction

   function automatic logic [3:0] input_onehot(input logic [3:0] code);
      case (code)
         PSO_IN_SE1:   input_onehot = 4'h1;
         PSO_IN_SE2:   input_onehot = 4'h2;
         PSO_IN_DIFF1: input_onehot = 4'h4;
         PSO_IN_DIFF2: input_onehot = 4'h8;
         default:      input_onehot = 4'h0;
      endcase
   endfunction

   // ==========================================================
   // registers
   logic [2:0]  state_ovr_r;
   logic [2:0]  state_ovr_nxt;
   logic [3:0]  forced_in_r;
   logic [3:0]  forced_in_nxt;

   // ==========================================================
   // write channel: address and data taken in either order
   logic        aw_held_r;
   logic [7:0]  aw_addr_r;
   logic        w_held_r;
   logic [31:0] w_data_r;
   logic [3:0]  w_strb_r;

   wire         aw_take   = s_axi_awvalid && s_axi_awready;
   wire         w_take    = s_axi_wvalid && s_axi_wready;
   wire         aw_have   = aw_held_r || aw_take;
   wire         w_have    = w_held_r || w_take;
   wire [7:0]   wr_addr   = aw_take ? s_axi_awaddr : aw_addr_r;
   wire [31:0]  wr_data   = w_take ? s_axi_wdata : w_data_r;
   wire [3:0]   wr_strb   = w_take ? s_axi_wstrb : w_strb_r;
   wire         wr_fire   = aw_have && w_have && !s_axi_bvalid;
   wire         wr_state  = wr_fire && (wr_addr == PSO_STATE_OVR_OFS) && wr_strb[0];
   wire         wr_input  = wr_fire && (wr_addr == PSO_FORCED_INPUT_OFS) && wr_strb[0];
   wire         wr_mapped = (wr_addr == PSO_STATE_OVR_OFS) || (wr_addr == PSO_FORCED_INPUT_OFS);

   // upper bits of the written byte are dropped here
   assign state_ovr_nxt = wr_state ? wr_data[PSO_STATE_MSB:0] : state_ovr_r;
   assign forced_in_nxt = wr_input ? wr_data[PSO_INPUT_MSB:0] : forced_in_r;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_held_r     <= 1'b0;
         aw_addr_r     <= 8'h00;
         w_held_r      <= 1'b0;
         w_data_r      <= 32'h0000_0000;
         w_strb_r      <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= PSO_RESP_OKAY;
      end
      else
      begin
         aw_held_r     <= aw_have && !wr_fire;
         w_held_r      <= w_have && !wr_fire;
         if (aw_take)
            aw_addr_r  <= s_axi_awaddr;
         if (w_take)
         begin
            w_data_r   <= s_axi_wdata;
            w_strb_r   <= s_axi_wstrb;
         end
         // ready drops once a beat is held, so one write at a time
         s_axi_awready <= !aw_have && !wr_fire && !s_axi_bvalid;
         s_axi_wready  <= !w_have && !wr_fire && !s_axi_bvalid;
         if (wr_fire)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? PSO_RESP_OKAY : PSO_RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_ovr_r <= PSO_STATE_OVR_RST;
         forced_in_r <= PSO_FORCED_INPUT_RST;
      end
      else
      begin
         state_ovr_r <= state_ovr_nxt;
         forced_in_r <= forced_in_nxt;
      end
   end

   // ==========================================================
   // read channel
   wire         ar_take  = s_axi_arvalid && s_axi_arready;
   wire         rd_state = s_axi_araddr == PSO_STATE_OVR_OFS;
   wire         rd_input = s_axi_araddr == PSO_FORCED_INPUT_OFS;
   wire         rd_stat  = s_axi_araddr == PSO_STATUS_OFS;
   wire [31:0]  rd_word  = rd_state ? {29'h0000_0000, state_ovr_r} :
                           rd_input ? {28'h000_0000, forced_in_r} :
                           rd_stat  ? {24'h00_0000, sm_force_r, sm_acquire_r, 3'h0, sm_state} :
                                      32'h0000_0000;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= PSO_RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !ar_take && !s_axi_rvalid;
         if (ar_take)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= (rd_state || rd_input || rd_stat) ? PSO_RESP_OKAY : PSO_RESP_SLVERR;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // ==========================================================
   // override logic
   wire         state_forced = state_code_forces(state_ovr_r);
   wire [3:0]   forced_hot   = input_onehot(forced_in_r);
   wire         input_forced = |forced_hot;
   wire [3:0]   valid_nxt    = mon_valid | forced_hot;
   wire         acquire_nxt  = input_forced && (sm_state != PSO_ST_LOCKED);
   wire [3:0]   fail_nxt     = mon_fail & ~forced_hot;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sm_force_r            <= 1'b0;
         sm_force_state_r      <= PSO_ST_AUTO;
         sm_mon_enable_r       <= 1'b1;
         sm_acquire_r          <= 1'b0;
         sm_holdover_inhibit_r <= 1'b0;
         input_valid_r         <= 4'h0;
         input_prio1_r         <= 4'h0;
         input_disq_inhibit_r  <= 4'h0;
         input_fail_r          <= 4'h0;
      end
      else
      begin
         sm_force_r            <= state_forced;
         sm_force_state_r      <= state_forced ? state_ovr_r : PSO_ST_AUTO;
         sm_mon_enable_r       <= !state_forced;
         sm_acquire_r          <= acquire_nxt;
         sm_holdover_inhibit_r <= input_forced;
         input_valid_r         <= valid_nxt;
         input_prio1_r         <= forced_hot;
         input_disq_inhibit_r  <= forced_hot;
         input_fail_r          <= fail_nxt;
      end
   end

   // ==========================================================
   // checks
   state_reset_a: assert property (@(posedge mclk) $rose(rst_n) |-> state_ovr_r == PSO_ST_AUTO)
      else $error("state override not automatic after reset");

   input_reset_a: assert property (@(posedge mclk) $rose(rst_n) |-> forced_in_r == PSO_FORCED_INPUT_RST)
      else $error("forced input field not at its reset value");

   state_force_a: assert property (@(posedge mclk) disable iff (!rst_n)
      state_code_forces(state_ovr_r) |=> sm_force_r && sm_force_state_r == $past(state_ovr_r))
      else $error("forced state not presented to the machine");

   auto_run_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !state_code_forces(state_ovr_r) |=> !sm_force_r)
      else $error("machine forced while override is automatic");

   unused_state_a: assert property (@(posedge mclk) disable iff (!rst_n)
      state_ovr_r == PSO_ST_UNUSED |=> !sm_force_r && sm_mon_enable_r)
      else $error("unused state code forced the machine");

   mon_block_a: assert property (@(posedge mclk) disable iff (!rst_n)
      state_code_forces(state_ovr_r) |=> !sm_mon_enable_r)
      else $error("monitors enabled while a state is forced");

   mon_free_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !state_code_forces(state_ovr_r) |=> sm_mon_enable_r && sm_force_state_r == PSO_ST_AUTO)
      else $error("monitors blocked while the machine runs itself");

   input_valid_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (input_onehot(forced_in_r) != 4'h0) |=> (input_valid_r & input_prio1_r) == input_prio1_r)
      else $error("forced input not treated as valid");

   prio_onehot_a: assert property (@(posedge mclk) disable iff (!rst_n)
      $onehot0(input_prio1_r))
      else $error("more than one input raised to top priority");

   prio_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
      forced_in_r == PSO_IN_AUTO |=> input_prio1_r == 4'h0)
      else $error("priority raised while selection is automatic");

   auto_input_a: assert property (@(posedge mclk) disable iff (!rst_n)
      input_onehot(forced_in_r) == 4'h0 |=> input_disq_inhibit_r == 4'h0 && !sm_holdover_inhibit_r)
      else $error("force side effects while selection is automatic");

   mon_pass_a: assert property (@(posedge mclk) disable iff (!rst_n)
      input_onehot(forced_in_r) == 4'h0 |=> input_valid_r == $past(mon_valid) && input_fail_r == $past(mon_fail))
      else $error("monitor results altered without a forced input");

   single_force_a: assert property (@(posedge mclk) disable iff (!rst_n)
      $onehot0(input_disq_inhibit_r))
      else $error("more than one input protected from disqualification");

   acquire_req_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (|input_onehot(forced_in_r)) && sm_state != PSO_ST_LOCKED |=> sm_acquire_r)
      else $error("no acquisition toward locked with forced input");

   locked_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
      sm_state == PSO_ST_LOCKED |=> !sm_acquire_r)
      else $error("acquisition requested while already locked");

   acq_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
      input_onehot(forced_in_r) == 4'h0 |=> !sm_acquire_r)
      else $error("acquisition requested without a forced input");

   forced_fail_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (input_fail_r & input_prio1_r) == 4'h0)
      else $error("forced input reported as failed");

   holdover_block_a: assert property (@(posedge mclk) disable iff (!rst_n)
      |input_prio1_r |-> sm_holdover_inhibit_r)
      else $error("holdover allowed with a forced input");

   upper_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
      s_axi_rvalid && s_axi_rresp == PSO_RESP_OKAY |-> s_axi_rdata[31:8] == 24'h00_0000)
      else $error("upper read bits not zero");

   masked_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
      wr_fire && !wr_strb[0] |=> $stable(state_ovr_r) && $stable(forced_in_r))
      else $error("write with low byte lane off changed a register");

   unused_code_a: assert property (@(posedge mclk) disable iff (!rst_n)
      forced_in_r == 4'h1 || forced_in_r == 4'hF |=> input_prio1_r == 4'h0)
      else $error("unused forced code selected an input");

   unused_input_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (forced_in_r == 4'h2 || forced_in_r > PSO_IN_DIFF2) |=> input_prio1_r == 4'h0 && !sm_holdover_inhibit_r)
      else $error("unused forced code acted as a force");

   // ==========================================================
   // bus handshake: readies stay low while an answer is pending
   unmapped_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
      wr_fire && !wr_mapped |=> s_axi_bresp == PSO_RESP_SLVERR && $stable(state_ovr_r) && $stable(forced_in_r))
      else $error("unmapped write not refused");

   aw_refuse_a: assert property (@(posedge mclk) disable iff (!rst_n)
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while a response is pending");

   ar_refuse_a: assert property (@(posedge mclk) disable iff (!rst_n)
      s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while read data is pending");

   bvalid_drop_a: assert property (@(posedge mclk) disable iff (!rst_n)
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated after handshake");

   rvalid_drop_a: assert property (@(posedge mclk) disable iff (!rst_n)
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data repeated after handshake");

endmodule // pso_override

`default_nettype wire

// *** tb/pso_override_bench.sv ***
// testbench: bus-driven checks of the pll state and input override block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) \
   begin failures++; $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module pso_override_bench;
   import pso_pkg::*;
   // ==========================================================
   // stimulus, observed outputs and counters
   logic        mclk = 1'h0;
   logic        rst_n = 1'h0;
   logic [7:0]  s_axi_awaddr = 8'h00;
   logic        s_axi_awvalid = 1'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic        s_axi_wvalid = 1'h0;
   logic        s_axi_bready = 1'h0;
   logic [7:0]  s_axi_araddr = 8'h00;
   logic        s_axi_arvalid = 1'h0;
   logic        s_axi_rready = 1'h0;
   logic [2:0]  sm_state = 3'h0;
   logic [3:0]  mon_valid = 4'h0;
   logic [3:0]  mon_fail = 4'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic        sm_force_r, sm_mon_enable_r, sm_acquire_r, sm_holdover_inhibit_r;
   logic [2:0]  sm_force_state_r;
   logic [3:0]  input_valid_r, input_prio1_r, input_disq_inhibit_r, input_fail_r;
   logic [2:0]  st;
   logic [3:0]  fi;
   logic [3:0]  oh;
   int          failures = 0;
   int          num_checks = 0;

   always #25 mclk = ~mclk;

   pso_override dut (.mclk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sm_state, .mon_valid, .mon_fail,
      .sm_force_r, .sm_force_state_r, .sm_mon_enable_r, .sm_acquire_r, .sm_holdover_inhibit_r, .input_valid_r,
      .input_prio1_r, .input_disq_inhibit_r, .input_fail_r);

   // ==========================================================
   // closing report, the single exit of the run
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ==========================================================
   // bus master; each channel held until its own ready
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      int n;
      bit aw, w, done;
      n = 0;
      aw = 0;
      w = 0;
      done = 0;
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'h1;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do
      begin
         @(posedge mclk);
         n++;
         if (aw && w && s_axi_bvalid === 1'h1)
         begin
            `CHK(s_axi_bresp, er)
            s_axi_bready <= 1'h0;
            done = 1;
         end
         if (!aw && s_axi_awready === 1'h1)
         begin
            aw = 1;
            s_axi_awvalid <= 1'h0;
         end
         if (!w && s_axi_wready === 1'h1)
         begin
            w = 1;
            s_axi_wvalid <= 1'h0;
         end
      end
      while (!done && n < 40);
      if (!done)
      begin
         failures++;
         complete_run();
      end
   endtask

   task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      bit ar, done;
      n = 0;
      ar = 0;
      done = 0;
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do
      begin
         @(posedge mclk);
         n++;
         if (ar && s_axi_rvalid === 1'h1)
         begin
            `CHK(s_axi_rdata, ed)
            `CHK(s_axi_rresp, er)
            s_axi_rready <= 1'h0;
            done = 1;
         end
         if (!ar && s_axi_arready === 1'h1)
         begin
            ar = 1;
            s_axi_arvalid <= 1'h0;
         end
      end
      while (!done && n < 40);
      if (!done)
      begin
         failures++;
         complete_run();
      end
   endtask

   // bench's own map of forced codes to selector lanes
   function automatic logic [3:0] sel_hot(input logic [3:0] c);
      case (c)
         4'h3: return 4'h1;
         4'h4: return 4'h2;
         4'h5: return 4'h4;
         4'h6: return 4'h8;
         default: return 4'h0;
      endcase
   endfunction

   // ==========================================================
   // test sequence
   initial
   begin
      repeat (20) @(posedge mclk);
      rst_n <= 1'h1;
      repeat (2) @(posedge mclk);
      axi_read(PSO_STATE_OVR_OFS, 32'h0, PSO_RESP_OKAY);
      axi_read(PSO_FORCED_INPUT_OFS, 32'hF, PSO_RESP_OKAY);
      `CHK(sm_mon_enable_r, 1'h1)
      $display("test reset values done");
      sm_state <= PSO_ST_HOLDOVER;
      // upper bits set on purpose: they must not stick
      for (int c = 0; c < 8; c++)
      begin
         st = 3'(c);
         axi_write(PSO_STATE_OVR_OFS, {29'h1FFFFFFF, st}, 4'hF, PSO_RESP_OKAY);
         repeat (2) @(posedge mclk);
         `CHK(sm_force_r, (st != 3'h0 && st != 3'h3))
         `CHK(sm_force_state_r, (st == 3'h3) ? 3'h0 : st)
         `CHK(sm_mon_enable_r, (st == 3'h0 || st == 3'h3))
         axi_read(PSO_STATE_OVR_OFS, {29'h0, st}, PSO_RESP_OKAY);
      end
      axi_read(PSO_STATUS_OFS, 32'h82, PSO_RESP_OKAY);
      $display("test state codes done");
      mon_valid <= 4'h8;
      mon_fail <= 4'hF;
      for (int c = 0; c < 16; c++)
      begin
         fi = 4'(c);
         oh = sel_hot(fi);
         axi_write(PSO_FORCED_INPUT_OFS, {28'hFFFFFFF, fi}, 4'hF, PSO_RESP_OKAY);
         repeat (2) @(posedge mclk);
         `CHK(input_prio1_r, oh)
         `CHK(input_valid_r, oh | 4'h8)
         `CHK(input_disq_inhibit_r, oh)
         `CHK(input_fail_r, ~oh)
         `CHK(sm_holdover_inhibit_r, |oh)
         `CHK(sm_acquire_r, |oh)
         axi_read(PSO_FORCED_INPUT_OFS, {28'h0, fi}, PSO_RESP_OKAY);
      end
      $display("test forced inputs done");
      axi_write(PSO_FORCED_INPUT_OFS, 32'h4, 4'hF, PSO_RESP_OKAY);
      sm_state <= PSO_ST_LOCKED;
      repeat (3) @(posedge mclk);
      `CHK(sm_acquire_r, 1'h0)
      sm_state <= PSO_ST_PRELOCK;
      repeat (3) @(posedge mclk);
      `CHK(sm_acquire_r, 1'h1)
      axi_write(PSO_FORCED_INPUT_OFS, 32'h0, 4'hF, PSO_RESP_OKAY);
      repeat (2) @(posedge mclk);
      `CHK(input_prio1_r, 4'h0)
      $display("test acquisition done");
      // unmapped place, masked lane and status view
      axi_write(8'h0C, 32'h5, 4'hF, PSO_RESP_SLVERR);
      axi_read(8'h0C, 32'h0, PSO_RESP_SLVERR);
      axi_write(PSO_STATE_OVR_OFS, 32'h1, 4'hE, PSO_RESP_OKAY);
      axi_read(PSO_STATE_OVR_OFS, 32'h7, PSO_RESP_OKAY);
      axi_read(PSO_STATUS_OFS, 32'h86, PSO_RESP_OKAY);
      $display("test bus corners done");
      complete_run();
   end

   // hang guard
   initial
   begin
      repeat (20000) @(posedge mclk);
      failures++;
      complete_run();
   end
endmodule // pso_override_bench
`default_nettype wire
